/* rtl/ssr_pkg.sv */
package ssr_pkg;

  // ***********************************************************************
  // Word and buffer sizes
  // ***********************************************************************
  localparam int WORD_W = 8;                  // Widest received word
  localparam int FIFO_DEPTH = 8;              // Words queued ahead of the buffer
  localparam int BITCNT_W = 4;                // Holds counts up to eight

  // ***********************************************************************
  // Receive length field
  // ***********************************************************************
  localparam logic [BITCNT_W-1:0] LEN_FULL = 4'h8;   // Length select low: 8 bits
  localparam logic [BITCNT_W-1:0] LEN_SHORT = 4'h7;  // Length select high: 7 bits

  // ***********************************************************************
  // Divide-by-four baud counter phases
  // ***********************************************************************
  localparam logic [1:0] CNT_START = 2'h3;    // Idle and start value, pin high
  localparam logic [1:0] PHASE_SAMPLE = 2'h0; // First count cycle: sample data
  localparam logic [1:0] PHASE_SHIFT = 2'h1;  // Second count cycle: shift data
  localparam int CNT_MSB = 1;                 // Counter bit that drives the pin

  // ***********************************************************************
  // Controller states, one-hot
  // ***********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,                        // No reception enabled
    ST_STALL = 3'b010,                        // Enabled, waiting for queue room
    ST_RUN   = 3'b100                         // Clocking bits in
  } ssr_state_e;

  // ***********************************************************************
  // Registered state of the receiver, apart from the queue and the pin synchroniser
  // ***********************************************************************
  typedef struct packed {
    ssr_state_e state;                        // Controller state
    logic [1:0] cnt;                          // Baud counter
    logic sample;                             // Bit caught in the sample phase
    logic [WORD_W-1:0] shreg;                 // Receive shift register
    logic [BITCNT_W-1:0] bits;                // Bits shifted so far
    logic enable;                             // Receive enable bit
    logic done;                               // Receive done flag
    logic overrun;                            // Overrun error flag
    logic [WORD_W-1:0] buf_data;              // Serial buffer register
    logic buf_valid;                          // Buffer holds an unread word
    logic push;                               // Word offered to the queue
    logic [WORD_W-1:0] push_data;             // Word being offered
    logic clk_prev;                           // Last filtered clock pin level
  } ssr_rx_s;

  localparam ssr_rx_s RX_RESET = '{
    state: ST_IDLE,
    cnt: CNT_START,
    sample: 1'b0,
    shreg: 8'h00,
    bits: 4'h0,
    enable: 1'b0,
    done: 1'b0,
    overrun: 1'b0,
    buf_data: 8'h00,
    buf_valid: 1'b0,
    push: 1'b0,
    push_data: 8'h00,
    clk_prev: 1'b1
  };

  // ***********************************************************************
  // Helpers
  // ***********************************************************************
  // Bits in a word for the given length select
  function automatic logic [BITCNT_W-1:0] ssr_len(input logic short_sel);
    ssr_len = short_sel ? LEN_SHORT : LEN_FULL;
  endfunction

  // Shift one bit in from the top, so the first bit ends lowest
  function automatic logic [WORD_W-1:0] ssr_shift(input logic [WORD_W-1:0] sh, input logic bit_in);
    ssr_shift = {bit_in, sh[WORD_W-1:1]};
  endfunction

endpackage

/* rtl/ssr_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************************
// Valid/ready word channel through the receive queue
// ***********************************************************************
interface ssr_fifo_if #(
  parameter int WIDTH = 8
);
  logic in_valid;                             // Producer offers a word
  logic in_ready;                             // Queue has room
  logic [WIDTH-1:0] in_data;                  // Offered word
  logic out_valid;                            // Queue holds a word
  logic out_ready;                            // Consumer takes the word
  logic [WIDTH-1:0] out_data;                 // Oldest word

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

`default_nettype wire

/* rtl/ssr_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************************
// Three-stage pin synchroniser with agreement filter
// ***********************************************************************
module ssr_sync3 #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;                     // First stage, read only by s2
    logic [WIDTH-1:0] s2;                     // Second stage
    logic [WIDTH-1:0] s3;                     // Third stage
    logic [WIDTH-1:0] level;                  // Accepted level
  } ssr_sync_s;

  ssr_sync_s s_r;
  ssr_sync_s s_nxt;

  // Next state: a bit changes once stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.level[i] = s_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '{s1: INIT, s2: INIT, s3: INIT, level: INIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.level;

endmodule

`default_nettype wire

/* rtl/ssr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************************
// Receive word queue
// ***********************************************************************
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  ssr_fifo_if.fifo q
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;                          // Write pointer with wrap bit
    logic [AW:0] rd;                          // Read pointer with wrap bit
  } ssr_ptr_s;

  ssr_ptr_s s_r;
  ssr_ptr_s s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];              // Word storage
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // Honest full and empty from the pointers
  assign empty = (s_r.wr == s_r.rd);
  assign full = (s_r.wr[AW] != s_r.rd[AW]) && (s_r.wr[AW-1:0] == s_r.rd[AW-1:0]);
  assign q.in_ready = !full;
  assign q.out_valid = !empty;
  assign q.out_data = mem[s_r.rd[AW-1:0]];
  assign do_wr = q.in_valid && !full;
  assign do_rd = q.out_ready && !empty;

  // Pointer advance
  always_comb begin
    s_nxt = s_r;
    if (do_wr) begin
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (do_rd) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
  end

  // Pointer register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem[s_r.wr[AW-1:0]] <= q.in_data;
    end
  end

endmodule

`default_nettype wire

/* rtl/ssr_receiver.sv */
`timescale 1ns/1ps
`default_nettype none

module ssr_receiver
  import ssr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic baud_tick_i,
  input wire logic receive_slave_select_i,
  input wire logic receive_enable_set_i,
  input wire logic receive_length_select_i,
  input wire logic rxd_i,
  input wire logic receive_clock_pin_i,
  output logic receive_clock_pin_o,
  output logic receive_clock_pin_oe_o,
  output logic receive_enable_bit_o,
  output logic receive_stall_o,
  output logic [WORD_W-1:0] serial_buffer_reg_o,
  output logic buffer_valid_o,
  input wire logic buffer_read_i,
  output logic receive_done_flag_o,
  output logic overrun_error_flag_o,
  input wire logic status_clear_i
);

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  ssr_rx_s s_r;                               // Registered state
  ssr_rx_s s_nxt;                             // Next state
  logic [1:0] pins;                           // Filtered pins: {clock, data}
  logic rxd_s;                                // Filtered data pin
  logic rxc_s;                                // Filtered clock pin
  logic room;                                 // Queue can take a word now
  logic got_bit;                              // A bit enters the shift register
  logic bit_val;                              // Value of that bit
  logic [WORD_W-1:0] sh_new;                  // Shift register after the bit
  logic [BITCNT_W-1:0] bits_new;              // Bit count after the bit
  logic [WORD_W-1:0] word;                    // Finished word, right aligned

  ssr_fifo_if #(.WIDTH(WORD_W)) q ();

  // ***********************************************************************
  // Pin synchronisers and word queue
  // ***********************************************************************
  ssr_sync3 #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .pin_i({receive_clock_pin_i, rxd_i}),
    .level_o(pins)
  );

  ssr_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .q(q)
  );

  assign rxd_s = pins[0];
  assign rxc_s = pins[1];

  // Queue input is fed from the registered push
  assign q.in_valid = s_r.push;
  assign q.in_data = s_r.push_data;
  // Buffer takes a word when empty or being read this cycle
  assign q.out_ready = !s_r.buf_valid || buffer_read_i;
  // Room only if no push is still in flight
  assign room = q.in_ready && !s_r.push;

  // ***********************************************************************
  // Bit engine
  // ***********************************************************************
  // Picks where the next bit comes from in the chosen sync mode
  always_comb begin
    got_bit = 1'b0;
    bit_val = 1'b0;
    if (s_r.state == ST_RUN) begin
      if (!receive_slave_select_i) begin
        // Master: shift the held sample in the second count cycle
        if (baud_tick_i && (s_r.cnt == PHASE_SHIFT)) begin
          got_bit = 1'b1;
          bit_val = s_r.sample;
        end
      end else begin
        // Slave: falling edge of the external clock takes the data
        if (s_r.clk_prev && !rxc_s) begin
          got_bit = 1'b1;
          bit_val = rxd_s;
        end
      end
    end
  end

  // Shifted value, count and aligned word
  always_comb begin
    sh_new = ssr_shift(s_r.shreg, bit_val);
    bits_new = s_r.bits + 4'h1;
    if (receive_length_select_i) begin
      // Seven bits sit in the top; move them down to bit zero
      word = {1'b0, sh_new[WORD_W-1:1]};
    end else begin
      word = sh_new;
    end
  end

  // ***********************************************************************
  // Next-state logic
  // ***********************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    s_nxt.clk_prev = rxc_s;

    // Software clears the flags; a set later in this block wins
    if (status_clear_i) begin
      s_nxt.done = 1'b0;
      s_nxt.overrun = 1'b0;
    end

    // Buffer refill from the queue, or release on read
    if (q.out_valid && q.out_ready) begin
      s_nxt.buf_data = q.out_data;
      s_nxt.buf_valid = 1'b1;
    end else if (buffer_read_i) begin
      s_nxt.buf_valid = 1'b0;
    end

    unique case (s_r.state)
      ST_IDLE: begin
        // Writing one to enable arms a reception
        if (receive_enable_set_i) begin
          s_nxt.enable = 1'b1;
          s_nxt.cnt = CNT_START;
          s_nxt.bits = 4'h0;
          s_nxt.shreg = 8'h00;
          // Back-pressure: hold off clocking while the queue is full
          s_nxt.state = room ? ST_RUN : ST_STALL;
        end
      end
      ST_STALL: begin
        // Start as soon as a queue slot is free
        if (room) begin
          s_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        // Divide-by-four counter runs on baud ticks in master mode
        if (!receive_slave_select_i && baud_tick_i) begin
          s_nxt.cnt = s_r.cnt + 2'h1;
          if (s_r.cnt == PHASE_SAMPLE) begin
            s_nxt.sample = rxd_s;
          end
        end
        // A bit arrives
        if (got_bit) begin
          s_nxt.shreg = sh_new;
          s_nxt.bits = bits_new;
          // Enough bits for the chosen length ends the reception
          if (bits_new == ssr_len(receive_length_select_i)) begin
            s_nxt.push = 1'b1;
            s_nxt.push_data = word;
            s_nxt.done = 1'b1;
            // Previous word still unacknowledged: report overrun
            if (s_r.done) begin
              s_nxt.overrun = 1'b1;
            end
            // Hardware drops enable, stopping the clock
            s_nxt.enable = 1'b0;
            s_nxt.cnt = CNT_START;
            s_nxt.state = ST_IDLE;
          end
        end
      end
    endcase
  end

  // ***********************************************************************
  // State register
  // ***********************************************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= RX_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  // Counter top bit is the clock; idle value keeps the pin high
  assign receive_clock_pin_o = s_r.cnt[CNT_MSB];
  // Pin driven only when this end is master
  assign receive_clock_pin_oe_o = !receive_slave_select_i;
  assign receive_enable_bit_o = s_r.enable;
  assign receive_stall_o = (s_r.state == ST_STALL);
  assign serial_buffer_reg_o = s_r.buf_data;
  assign buffer_valid_o = s_r.buf_valid;
  assign receive_done_flag_o = s_r.done;
  assign overrun_error_flag_o = s_r.overrun;

endmodule

`default_nettype wire

/* sim/ssr_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************************
// Far-side transmitter: follows the master clock pin, sends LSB first
// ***********************************************************************
module ssr_tx_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_pin_i,
  input wire logic load_i,
  input wire logic [7:0] word_i,
  input wire logic [3:0] nbits_i,
  output logic rxd_o
);
  logic pin_q; // Pin level one cycle ago
  logic [3:0] idx; // Next bit to send

  // New bit on each falling pin edge; line turns over once the frame is done
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= 1'b1;
      idx <= 4'h0;
      rxd_o <= 1'b1;
    end else begin
      pin_q <= clk_pin_i;
      if (load_i) begin
        idx <= 4'h0;
      end else if (pin_q && !clk_pin_i && idx < nbits_i) begin
        rxd_o <= word_i[idx[2:0]];
        idx <= idx + 4'h1;
      end else if (!pin_q && clk_pin_i && idx == nbits_i) begin
        // Hold time over: no stale bit is left on the line
        rxd_o <= ~rxd_o;
      end
    end
  end
endmodule

`default_nettype wire

/* sim/ssr_receiver_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************************
// Port-level checks of the receiver
// ***********************************************************************
module ssr_receiver_properties
  import ssr_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic baud_tick_i,
  input wire logic receive_slave_select_i,
  input wire logic receive_enable_set_i,
  input wire logic receive_length_select_i,
  input wire logic rxd_i,
  input wire logic receive_clock_pin_i,
  input wire logic receive_clock_pin_o,
  input wire logic receive_clock_pin_oe_o,
  input wire logic receive_enable_bit_o,
  input wire logic receive_stall_o,
  input wire logic [WORD_W-1:0] serial_buffer_reg_o,
  input wire logic buffer_valid_o,
  input wire logic buffer_read_i,
  input wire logic receive_done_flag_o,
  input wire logic overrun_error_flag_o,
  input wire logic status_clear_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  chk_oe_by_mode: assert property (receive_clock_pin_oe_o == !receive_slave_select_i)
    else $error("clock pin drive does not follow mode");
  chk_start_taken: assert property (receive_enable_set_i && !receive_enable_bit_o && !receive_stall_o
    |=> receive_enable_bit_o || receive_stall_o) else $error("enable write not taken");
  chk_pin_on_tick: assert property (!receive_slave_select_i && $changed(receive_clock_pin_o)
    |-> $past(baud_tick_i)) else $error("clock pin moved without a baud tick");
  chk_pin_idle_high: assert property (!receive_enable_bit_o && !receive_stall_o
    |-> receive_clock_pin_o) else $error("clock pin low while idle");
  chk_enable_holds: assert property (receive_enable_bit_o && !baud_tick_i && !receive_slave_select_i
    |=> receive_enable_bit_o) else $error("enable dropped without a tick");
  chk_end_flags: assert property ($fell(receive_enable_bit_o)
    |-> receive_done_flag_o && receive_clock_pin_o) else $error("end without done flag");
  chk_done_at_end: assert property ($rose(receive_done_flag_o) |-> $fell(receive_enable_bit_o))
    else $error("done set outside end of reception");
  chk_done_sticky: assert property (receive_done_flag_o && !status_clear_i |=> receive_done_flag_o)
    else $error("done flag lost");
  chk_overrun_cause: assert property ($rose(overrun_error_flag_o)
    |-> $fell(receive_enable_bit_o) && $past(receive_done_flag_o)) else $error("overrun without cause");
  chk_word_visible: assert property ($rose(receive_done_flag_o) && !buffer_valid_o && !buffer_read_i
    |-> ##2 buffer_valid_o) else $error("word not moved to buffer");
endmodule

bind ssr_receiver ssr_receiver_properties u_props (.clock_i, .resetn_i, .baud_tick_i, .receive_slave_select_i,
  .receive_enable_set_i, .receive_length_select_i, .rxd_i, .receive_clock_pin_i, .receive_clock_pin_o,
  .receive_clock_pin_oe_o, .receive_enable_bit_o, .receive_stall_o, .serial_buffer_reg_o, .buffer_valid_o,
  .buffer_read_i, .receive_done_flag_o, .overrun_error_flag_o, .status_clear_i);

`default_nettype wire

/* sim/ssr_receiver_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end

module ssr_receiver_tb;
  import ssr_pkg::*;
  // ***********************************************************************
  // Stimulus and observed signals
  // ***********************************************************************
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic tick = 1'b0, slave = 1'b0, en_set = 1'b0, len_sel = 1'b0, rd = 1'b0, clr = 1'b0, load = 1'b0;
  logic ext_pin = 1'b1; // Clock pin input, driven by the bench in slave mode
  logic sl_d = 1'b1; // Data pin level sent by the bench in slave mode
  logic rxd_in; // Data pin as the receiver sees it
  logic [2:0] tick_cnt = 3'h0; // Baud tick spacing
  logic [7:0] tx_word = 8'h00;
  logic [3:0] tx_len = 4'h8;
  logic pin_o, oe, en_o, stall, valid, done, ovr, rxd;
  logic [WORD_W-1:0] buf_d;
  int n_errors = 0;
  int checked = 0;

  // Clock of 4 ns and a baud tick every eighth cycle
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    tick_cnt <= tick_cnt + 3'h1;
    tick <= (tick_cnt == 3'h7);
  end

  ssr_receiver u_dut (.clock_i, .resetn_i, .baud_tick_i(tick), .receive_slave_select_i(slave),
    .receive_enable_set_i(en_set), .receive_length_select_i(len_sel), .rxd_i(rxd_in),
    .receive_clock_pin_i(ext_pin), .receive_clock_pin_o(pin_o), .receive_clock_pin_oe_o(oe),
    .receive_enable_bit_o(en_o), .receive_stall_o(stall), .serial_buffer_reg_o(buf_d),
    .buffer_valid_o(valid), .buffer_read_i(rd), .receive_done_flag_o(done),
    .overrun_error_flag_o(ovr), .status_clear_i(clr));

  ssr_tx_model u_tx (.clock_i, .resetn_i, .clk_pin_i(pin_o), .load_i(load), .word_i(tx_word),
    .nbits_i(tx_len), .rxd_o(rxd));

  // Slave mode takes its data from the bench, master mode from the sender model
  assign rxd_in = slave ? sl_d : rxd;

  // ***********************************************************************
  // Access tasks
  // ***********************************************************************
  task automatic print_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Load the sender and write one to the enable bit
  task automatic start(input logic [7:0] w, input logic short_sel);
    @(posedge clock_i);
    tx_word <= w;
    tx_len <= short_sel ? 4'h7 : 4'h8;
    len_sel <= short_sel;
    load <= 1'b1;
    en_set <= 1'b1;
    @(posedge clock_i);
    load <= 1'b0;
    en_set <= 1'b0;
  endtask

  // External master: data set while the clock is high, falling edge takes it
  task automatic slave_word(input logic [7:0] w);
    for (int b = 0; b < 8; b++) begin
      @(posedge clock_i);
      sl_d <= w[b];
      repeat (8) @(posedge clock_i);
      ext_pin <= 1'b0;
      repeat (8) @(posedge clock_i);
      ext_pin <= 1'b1;
    end
  endtask

  // Wait for the reception to end, then for the buffer copy
  task automatic finish_rx;
    int i;
    @(negedge clock_i);
    for (i = 0; i < 600 && (en_o !== 1'b0 || stall !== 1'b0); i++) @(negedge clock_i);
    repeat (3) @(negedge clock_i);
  endtask

  // Check the buffer word and consume it
  task automatic rd_word(input logic [7:0] exp);
    `CHK("buffer valid", 1'b1, valid)
    `CHK("buffer word", exp, buf_d)
    @(posedge clock_i);
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    repeat (3) @(negedge clock_i);
  endtask

  // ***********************************************************************
  // Test sequence
  // ***********************************************************************
  initial begin
    int i;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    `CHK("idle clock pin", 1'b1, pin_o)
    `CHK("enable at reset", 1'b0, en_o)
    `CHK("done at reset", 1'b0, done)
    `CHK("buffer at reset", 8'h00, buf_d)
    repeat (8) @(negedge clock_i);
    // Full word arrives LSB first
    start(8'hA5, 1'b0);
    finish_rx;
    `CHK("word 8 bit", 8'hA5, buf_d)
    `CHK("done set", 1'b1, done)
    `CHK("enable cleared", 1'b0, en_o)
    `CHK("no overrun", 1'b0, ovr)
    // Short word while done is still set
    start(8'hC3, 1'b1);
    finish_rx;
    `CHK("overrun set", 1'b1, ovr)
    rd_word(8'hA5);
    rd_word(8'h43);
    `CHK("buffer empty", 1'b0, valid)
    @(posedge clock_i);
    clr <= 1'b1;
    slave <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    @(negedge clock_i);
    `CHK("done cleared", 1'b0, done)
    `CHK("overrun cleared", 1'b0, ovr)
    `CHK("slave pin drive", 1'b0, oe)
    // Slave reception clocked from the pin
    start(8'h5A, 1'b0);
    slave_word(8'h5A);
    finish_rx;
    `CHK("slave done", 1'b1, done)
    `CHK("slave pin high", 1'b1, pin_o)
    rd_word(8'h5A);
    @(posedge clock_i);
    slave <= 1'b0;
    // Fill buffer and queue, then one more stalls
    for (i = 0; i < 9; i++) begin
      start(8'h10 + 8'(i), 1'b0);
      finish_rx;
    end
    start(8'h99, 1'b0);
    repeat (40) @(negedge clock_i);
    `CHK("stalled", 1'b1, stall)
    `CHK("no clock in stall", 1'b1, pin_o)
    for (i = 0; i < 9; i++) rd_word(8'h10 + 8'(i));
    finish_rx;
    rd_word(8'h99);
    print_verdict;
  end

  // Watchdog well beyond the expected run of about 3300 cycles
  initial begin
    #80000;
    n_errors++;
    print_verdict;
  end
endmodule

`default_nettype wire
